// ==== design/cfg_pkg.sv ====
// shared constants and carrier types for the configuration decoder
package cfg_pkg;

  // raw configuration word as it leaves the non-volatile array
  typedef struct packed {
    logic       watchdog_prescale_select;
    logic [3:0] watchdog_postscale_select;
    logic       pll_lock_wait_enable;
    logic       i2c_pin_alternate_select;
    logic [1:0] debug_channel_select;
    logic       pwm_reset_pin_owner;
    logic       high_side_polarity;
    logic       low_side_polarity;
  } cfg_fuse_t;

  localparam int FUSE_W = $bits(cfg_fuse_t);

  // decoded settings handed to the watchdog and debug units
  typedef struct packed {
    logic [7:0]  wdt_prescale_ratio;
    logic [15:0] wdt_postscale_ratio;
    logic [2:0]  debug_pair_onehot;
    logic        debug_select_reserved;
  } cfg_decoded_t;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // register byte addresses
  localparam logic [3:0] ADDR_DEVICE_IDENTIFIER = 4'h0;
  localparam logic [3:0] ADDR_SILICON_REVISION  = 4'h4;
  localparam logic [3:0] ADDR_STATUS            = 4'h8;
  localparam logic [3:0] ADDR_CONTROL           = 4'hC;

  // control register fields
  localparam int CTRL_PWM_TAKE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status register fields
  localparam int STAT_CORE_RUN_BIT = 12;
  localparam int STAT_CAPTURED_BIT = 13;
  localparam int STAT_PLL_LOCK_BIT = 14;

  localparam int ID_W = 24;

  // watchdog ratio encodings
  localparam logic [7:0] PRESCALE_RATIO_HI = 8'h80;
  localparam logic [7:0] PRESCALE_RATIO_LO = 8'h20;
  localparam logic [15:0] POSTSCALE_ONE    = 16'h0001;

  // debug channel codes
  localparam logic [1:0] DEBUG_CODE_ONE      = 2'h3;
  localparam logic [1:0] DEBUG_CODE_TWO      = 2'h2;
  localparam logic [1:0] DEBUG_CODE_THREE    = 2'h1;
  localparam logic [1:0] DEBUG_CODE_RESERVED = 2'h0;

  localparam int PWM_PAIRS = 3;

  // regulator start-up hold-off
  localparam int CLK_PERIOD_NS     = 10;
  localparam int STARTUP_TIME_NS   = 20000;
  localparam int STARTUP_CYC       =
    (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CNT_W     = $clog2(STARTUP_CYC + 1);
  localparam logic [STARTUP_CNT_W-1:0] STARTUP_LAST =
    STARTUP_CNT_W'(STARTUP_CYC - 1);

endpackage : cfg_pkg

// ==== design/sync_two_stage.sv ====
// two flip-flop synchroniser for levels arriving from outside the clock
`timescale 1ns/1ns
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,   // system clock
  input  wire logic             i_rst_n, // async reset, active low
  input  wire logic [WIDTH-1:0] i_async, // level from another domain
  output logic      [WIDTH-1:0] o_sync   // level safe to use
);

  logic [WIDTH-1:0] stage_one;

  // first stage feeds only the second, to bound metastability
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage_one <= '0;
      o_sync    <= '0;
    end else begin
      stage_one <= i_async;
      o_sync    <= stage_one;
    end
  end

endmodule : sync_two_stage

// ==== design/config_fuse_decode.sv ====
// configuration decode, identification words and start-up hold-off
// Overview of operation
// [RQ1] prescale bit one gives divide 128, zero gives divide 32
// [RQ2] four-bit postscale code n gives divide two to the power n
// [RQ3] with lock wait set, switch to pll completes only after lock
// [RQ4] i2c goes to primary pins when select is one, else alternate
// [RQ5] debug code 11, 10, 01 pick pairs one, two, three; 00 reserved
// [RQ6] owner bit one keeps pwm pins tri-stated until software hands over
// [RQ7] high-side pwm outputs active high when polarity one, else low
// [RQ8] low-side pwm outputs active high when polarity one, else low
// [RQ9] 24-bit device identifier is read-only, writes ignored
// [RQ10] 24-bit silicon revision is read-only, writes ignored
// [RQ11] after power-on, core held for about 20 us regulator start-up
// [RQ12] same hold-off applied on every resume after power-down
// [RQ13] decoded settings captured during reset, stable until next reset; code captures at end of first hold-off after reset release
`timescale 1ns/1ns
module config_fuse_decode #(
  parameter logic [23:0] DEVICE_ID_VALUE = 24'h00_1234, // arbitrary
  parameter logic [23:0] REVISION_VALUE  = 24'h00_0001  // arbitrary
) (
  input  wire logic                  i_clk,          // system clock
  input  wire logic                  i_rst_n,        // async reset
  input  wire cfg_pkg::cfg_fuse_t    i_fuse,         // raw config word
  input  wire logic                  i_power_down,   // regulator off
  input  wire logic                  i_pll_lock,     // pll lock, async
  input  wire logic                  i_switch_req,   // clock switch pulse
  input  wire logic                  i_switch_to_pll,// switch targets pll
  output logic                       o_switch_done,  // switch complete
  output logic                       o_core_run,     // core released
  output cfg_pkg::cfg_decoded_t      o_decoded,      // decoded settings
  input  wire logic                  i_i2c_sda_drive,// i2c pulls sda low
  input  wire logic                  i_i2c_scl_drive,// i2c pulls scl low
  output logic                       o_i2c_sda_in,   // sda seen by i2c
  output logic                       o_i2c_scl_in,   // scl seen by i2c
  input  wire logic                  i_pri_sda_in,   // primary data pin
  input  wire logic                  i_pri_scl_in,   // primary clock pin
  input  wire logic                  i_alt_sda_in,   // alternate data pin
  input  wire logic                  i_alt_scl_in,   // alternate clock pin
  output logic                       o_pri_sda_out,  // primary data out
  output logic                       o_pri_sda_oe,   // primary data oe
  output logic                       o_pri_scl_out,  // primary clock out
  output logic                       o_pri_scl_oe,   // primary clock oe
  output logic                       o_alt_sda_out,  // alternate data out
  output logic                       o_alt_sda_oe,   // alternate data oe
  output logic                       o_alt_scl_out,  // alternate clk out
  output logic                       o_alt_scl_oe,   // alternate clk oe
  input  wire logic [2:0]            i_pwm_high,     // high side, active
  input  wire logic [2:0]            i_pwm_low,      // low side, active
  output logic      [2:0]            o_pwm_high_pin, // high side pins
  output logic      [2:0]            o_pwm_low_pin,  // low side pins
  output logic      [2:0]            o_pwm_high_oe,  // high side oe
  output logic      [2:0]            o_pwm_low_oe,   // low side oe
  input  wire cfg_pkg::reg_req_t     i_bus,          // register request
  output logic      [31:0]           o_rdata         // read data
);
  import cfg_pkg::*;

  typedef enum logic [1:0] {HOLD, RUN, DOWN} hold_state_t;
  typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_DONE} switch_state_t;

  cfg_fuse_t                fuse_sync;
  cfg_fuse_t                cfg;
  logic                     captured;
  logic                     power_down_sync;
  logic                     pll_lock_sync;
  hold_state_t              hold_state;
  logic [STARTUP_CNT_W-1:0] hold_cnt;
  switch_state_t            sw_state;
  logic [31:0]              control;
  logic                     pwm_take;
  logic                     pri_sda_s, pri_scl_s, alt_sda_s, alt_scl_s;

  sync_two_stage #(.WIDTH(FUSE_W)) u_fuse_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_fuse),
    .o_sync  (fuse_sync)
  );

  sync_two_stage #(.WIDTH(2)) u_level_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async ({i_power_down, i_pll_lock}),
    .o_sync  ({power_down_sync, pll_lock_sync})
  );

  sync_two_stage #(.WIDTH(4)) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async ({i_pri_sda_in, i_pri_scl_in, i_alt_sda_in, i_alt_scl_in}),
    .o_sync  ({pri_sda_s, pri_scl_s, alt_sda_s, alt_scl_s})
  );

  // ---------------- start-up hold-off ----------------
  wire hold_expired = (hold_cnt == STARTUP_LAST);

  // [RQ11] power-on hold-off
  // [RQ12] resume hold-off
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_state <= HOLD;
      hold_cnt   <= '0;
      o_core_run <= 1'b0;
    end else begin
      case (hold_state)
        HOLD: begin
          hold_cnt <= hold_cnt + 1'b1;
          if (hold_expired) begin
            hold_state <= RUN;
            o_core_run <= 1'b1;
          end
        end
        RUN: begin
          if (power_down_sync) begin
            hold_state <= DOWN;
            o_core_run <= 1'b0;
          end
        end
        DOWN: begin
          hold_cnt <= '0;
          if (!power_down_sync) begin
            hold_state <= HOLD;
          end
        end
        default: begin
          hold_state <= HOLD;
          hold_cnt   <= '0;
          o_core_run <= 1'b0;
        end
      endcase
    end
  end

  // [RQ13] capture once
  // the fuse word is sampled through the whole first hold-off, long
  // after the synchroniser has settled, then frozen until reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg      <= '0;
      captured <= 1'b0;
    end else if (!captured) begin
      cfg <= fuse_sync;
      if (hold_state == HOLD && hold_expired) begin
        captured <= 1'b1;
      end
    end
  end

  // ---------------- watchdog and debug decode ----------------
  // [RQ1] prescale ratio
  wire [7:0] next_prescale = cfg.watchdog_prescale_select ?
                             PRESCALE_RATIO_HI : PRESCALE_RATIO_LO;
  // [RQ2] postscale ratio
  wire [15:0] next_postscale = POSTSCALE_ONE <<
                               cfg.watchdog_postscale_select;
  // [RQ5] debug pair select
  wire [2:0] next_debug_pair =
    {cfg.debug_channel_select == DEBUG_CODE_THREE,
     cfg.debug_channel_select == DEBUG_CODE_TWO,
     cfg.debug_channel_select == DEBUG_CODE_ONE};
  wire next_debug_reserved = captured &&
    (cfg.debug_channel_select == DEBUG_CODE_RESERVED);

  // outputs held quiet until capture so consumers never see raw bits
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_decoded <= '0;
    end else begin
      o_decoded.wdt_prescale_ratio    <= captured ? next_prescale : '0;
      o_decoded.wdt_postscale_ratio   <= captured ? next_postscale : '0;
      o_decoded.debug_pair_onehot     <= captured ? next_debug_pair : '0;
      o_decoded.debug_select_reserved <= next_debug_reserved;
    end
  end

  // ---------------- clock switch lock wait ----------------
  wire need_lock = cfg.pll_lock_wait_enable && i_switch_to_pll;

  // [RQ3] lock wait
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_state      <= SW_IDLE;
      o_switch_done <= 1'b0;
    end else begin
      o_switch_done <= 1'b0;
      case (sw_state)
        SW_IDLE: begin
          if (i_switch_req) begin
            sw_state <= need_lock ? SW_WAIT : SW_DONE;
          end
        end
        SW_WAIT: begin
          if (pll_lock_sync) begin
            sw_state <= SW_DONE;
          end
        end
        SW_DONE: begin
          o_switch_done <= 1'b1;
          sw_state      <= SW_IDLE;
        end
        default: begin
          sw_state <= SW_IDLE;
        end
      endcase
    end
  end

  // ---------------- i2c pin routing ----------------
  // [RQ4] i2c pin pair
  wire use_pri = cfg.i2c_pin_alternate_select;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pri_sda_oe <= 1'b0;
      o_pri_scl_oe <= 1'b0;
      o_alt_sda_oe <= 1'b0;
      o_alt_scl_oe <= 1'b0;
      o_i2c_sda_in <= 1'b1;
      o_i2c_scl_in <= 1'b1;
    end else begin
      o_pri_sda_oe <= captured && use_pri && i_i2c_sda_drive;
      o_pri_scl_oe <= captured && use_pri && i_i2c_scl_drive;
      o_alt_sda_oe <= captured && !use_pri && i_i2c_sda_drive;
      o_alt_scl_oe <= captured && !use_pri && i_i2c_scl_drive;
      o_i2c_sda_in <= use_pri ? pri_sda_s : alt_sda_s;
      o_i2c_scl_in <= use_pri ? pri_scl_s : alt_scl_s;
    end
  end
  // open-drain: the pins only ever pull low
  assign o_pri_sda_out = 1'b0;
  assign o_pri_scl_out = 1'b0;
  assign o_alt_sda_out = 1'b0;
  assign o_alt_scl_out = 1'b0;

  // ---------------- pwm ownership and polarity ----------------
  assign pwm_take = control[CTRL_PWM_TAKE_BIT];
  // [RQ6] pin ownership
  wire pwm_drive = captured && (!cfg.pwm_reset_pin_owner || pwm_take);
  // [RQ7] high polarity
  wire [2:0] next_high_pin = i_pwm_high ^ {PWM_PAIRS{~cfg.high_side_polarity}};
  // [RQ8] low polarity
  wire [2:0] next_low_pin = i_pwm_low ^ {PWM_PAIRS{~cfg.low_side_polarity}};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pwm_high_pin <= '0;
      o_pwm_low_pin  <= '0;
      o_pwm_high_oe  <= '0;
      o_pwm_low_oe   <= '0;
    end else begin
      o_pwm_high_pin <= next_high_pin;
      o_pwm_low_pin  <= next_low_pin;
      o_pwm_high_oe  <= {PWM_PAIRS{pwm_drive}};
      o_pwm_low_oe   <= {PWM_PAIRS{pwm_drive}};
    end
  end

  // ---------------- register port ----------------
  wire sel_id   = (i_bus.addr == ADDR_DEVICE_IDENTIFIER);
  wire sel_rev  = (i_bus.addr == ADDR_SILICON_REVISION);
  wire sel_stat = (i_bus.addr == ADDR_STATUS);
  wire sel_ctrl = (i_bus.addr == ADDR_CONTROL);

  wire [31:0] status_word = {17'h0_0000, pll_lock_sync, captured,
                             o_core_run, cfg};
  // [RQ9] identifier read-only
  // [RQ10] revision read-only
  wire [31:0] next_rdata =
    !i_bus.rd ? 32'h0000_0000 :
    sel_id    ? {8'h00, DEVICE_ID_VALUE} :
    sel_rev   ? {8'h00, REVISION_VALUE} :
    sel_stat  ? status_word :
    sel_ctrl  ? control : 32'h0000_0000;

  // only the control word is writable; other addresses drop writes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control <= CTRL_RESET;
      o_rdata <= '0;
    end else begin
      if (i_bus.wr && sel_ctrl) begin
        control <= {31'h0000_0000, i_bus.wdata[CTRL_PWM_TAKE_BIT]};
      end
      o_rdata <= next_rdata;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic [STARTUP_CNT_W:0] run_gap;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_gap <= '0;
    end else if (o_core_run) begin
      run_gap <= '0;
    end else begin
      run_gap <= run_gap + 1'b1;
    end
  end

  sequence s_switch_wait;
    i_switch_req && sw_state == SW_IDLE && need_lock && !pll_lock_sync;
  endsequence
  sequence s_resume;
    hold_state == DOWN && !power_down_sync;
  endsequence

  prescale_decode_a: assert property ( // [RQ1]
    captured |=> o_decoded.wdt_prescale_ratio ==
      ($past(cfg.watchdog_prescale_select) ? 8'h80 : 8'h20))
    else $error("prescale ratio wrong");
  postscale_decode_a: assert property ( // [RQ2]
    captured |=> o_decoded.wdt_postscale_ratio ==
      (16'h0001 << $past(cfg.watchdog_postscale_select)))
    else $error("postscale ratio wrong");
  lock_wait_a: assert property ( // [RQ3]
    s_switch_wait ##1 !pll_lock_sync |=> !o_switch_done [*2])
    else $error("switch done without pll lock");
  no_wait_a: assert property ( // [RQ3]
    (i_switch_req && sw_state == SW_IDLE && !need_lock) |-> ##2 o_switch_done)
    else $error("switch without lock wait not done in two cycles");
  i2c_route_a: assert property ( // [RQ4]
    (captured && i_i2c_sda_drive) |=>
      (o_pri_sda_oe == $past(use_pri)) && (o_alt_sda_oe == !$past(use_pri)))
    else $error("i2c data routed to wrong pin pair");
  debug_pair_a: assert property ( // [RQ5]
    (captured && cfg.debug_channel_select == 2'h3) |=>
      o_decoded.debug_pair_onehot == 3'h1)
    else $error("debug pair one not selected");
  pwm_owner_a: assert property ( // [RQ6]
    (captured && cfg.pwm_reset_pin_owner && !pwm_take) |=>
      o_pwm_high_oe == 3'h0 && o_pwm_low_oe == 3'h0)
    else $error("pwm pins driven while port owns them");
  high_polarity_a: assert property ( // [RQ7]
    captured |=> o_pwm_high_pin ==
      ($past(i_pwm_high) ^ {3{~$past(cfg.high_side_polarity)}}))
    else $error("high side polarity wrong");
  low_polarity_a: assert property ( // [RQ8]
    captured |=> o_pwm_low_pin ==
      ($past(i_pwm_low) ^ {3{~$past(cfg.low_side_polarity)}}))
    else $error("low side polarity wrong");
  id_read_a: assert property ( // [RQ9]
    (i_bus.rd && sel_id) |=> o_rdata == {8'h00, DEVICE_ID_VALUE})
    else $error("device identifier read wrong");
  rev_read_a: assert property ( // [RQ10]
    (i_bus.rd && sel_rev) |=> o_rdata == {8'h00, REVISION_VALUE})
    else $error("silicon revision read wrong");
  holdoff_len_a: assert property ( // [RQ11]
    $rose(o_core_run) |-> run_gap >= STARTUP_CYC)
    else $error("core released before start-up interval");
  resume_hold_a: assert property ( // [RQ12]
    s_resume |=> !o_core_run [*8])
    else $error("core released too early after power-down");
  cfg_stable_a: assert property ( // [RQ13]
    captured |=> $stable(cfg))
    else $error("captured configuration changed");

endmodule : config_fuse_decode

// ==== verification/pll_i2c_model.sv ====
// far-side model: pll lock source and open-drain i2c pins with pull-ups
`timescale 1ns/1ns
module pll_i2c_model (
  input  wire logic       i_clk,       // system clock
  input  wire logic       i_rst_n,     // async reset, active low
  input  wire logic       i_relock,    // pulse: pll starts to relock
  input  wire logic [7:0] i_lock_wait, // cycles until lock returns
  input  wire logic [1:0] i_scl_hold,  // outside device holds scl low
  input  wire logic [3:0] i_pin_out,   // {alt scl,alt sda,pri scl,pri sda}
  input  wire logic [3:0] i_pin_oe,    // enables, same order
  output logic      [3:0] o_pin,       // resolved pin levels
  output logic            o_pll_lock   // pll lock indication
);
  logic [7:0] count;

  // a released line floats high through its pull-up, never holds old data
  assign o_pin = ~(i_pin_oe & ~i_pin_out)
               & ~{i_scl_hold[1], 1'b0, i_scl_hold[0], 1'b0};

  // lock drops at once and only returns after the commanded wait
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count      <= 8'h00;
      o_pll_lock <= 1'b1;
    end else if (i_relock) begin
      count      <= i_lock_wait;
      o_pll_lock <= 1'b0;
    end else if (count != 8'h00) begin
      count      <= count - 8'h01;
      o_pll_lock <= (count == 8'h01);
    end
  end
endmodule : pll_i2c_model

// ==== verification/config_fuse_decode_tb.sv ====
// self-checking bench for the configuration decoder
`timescale 1ns/1ns
module config_fuse_decode_tb;
  import cfg_pkg::*;
  localparam logic [23:0] ID_VAL  = 24'h00_5A3C; // arbitrary
  localparam logic [23:0] REV_VAL = 24'h00_0C07; // arbitrary
  logic         i_clk, i_rst_n, power_down, switch_req, to_pll, relock;
  logic         sda_drive, scl_drive;
  logic   [2:0] pwm_high, pwm_low;
  logic   [1:0] scl_hold;
  cfg_fuse_t    fuse;
  reg_req_t     bus;
  wire    [3:0] pin_out, pin_oe, pin;
  wire    [2:0] hi_pin, lo_pin, hi_oe, lo_oe;
  wire   [31:0] rdata;
  wire          switch_done, core_run, sda_in, scl_in, pll_lock;
  cfg_decoded_t decoded;
  int           failures, tests_run;
  logic  [31:0] d;
  int           n;
  // every debug code, both values of each bit, postscale 0, 1, E and F
  cfg_fuse_t    cfgs[4] = '{12'hFFD, 12'h00A, 12'h8D3, 12'h724};

  config_fuse_decode #(.DEVICE_ID_VALUE(ID_VAL), .REVISION_VALUE(REV_VAL))
  u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_fuse(fuse),
    .i_power_down(power_down), .i_pll_lock(pll_lock),
    .i_switch_req(switch_req), .i_switch_to_pll(to_pll),
    .o_switch_done(switch_done), .o_core_run(core_run),
    .o_decoded(decoded), .i_i2c_sda_drive(sda_drive),
    .i_i2c_scl_drive(scl_drive), .o_i2c_sda_in(sda_in),
    .o_i2c_scl_in(scl_in), .i_pri_sda_in(pin[0]), .i_pri_scl_in(pin[1]),
    .i_alt_sda_in(pin[2]), .i_alt_scl_in(pin[3]),
    .o_pri_sda_out(pin_out[0]), .o_pri_sda_oe(pin_oe[0]),
    .o_pri_scl_out(pin_out[1]), .o_pri_scl_oe(pin_oe[1]),
    .o_alt_sda_out(pin_out[2]), .o_alt_sda_oe(pin_oe[2]),
    .o_alt_scl_out(pin_out[3]), .o_alt_scl_oe(pin_oe[3]),
    .i_pwm_high(pwm_high), .i_pwm_low(pwm_low), .o_pwm_high_pin(hi_pin),
    .o_pwm_low_pin(lo_pin), .o_pwm_high_oe(hi_oe), .o_pwm_low_oe(lo_oe),
    .i_bus(bus), .o_rdata(rdata));

  pll_i2c_model u_far (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_relock(relock),
    .i_lock_wait(8'h28), .i_scl_hold(scl_hold), .i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .o_pin(pin), .o_pll_lock(pll_lock));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
  endtask : step

  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge i_clk);
    bus <= '0;
  endtask : reg_write

  // read data stand only in the cycle after the taking edge
  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_clk);
    bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge i_clk);
    bus <= '0;
    @(negedge i_clk);
    v = rdata;
  endtask : reg_read

  task automatic run_cfg(input cfg_fuse_t f);
    logic [2:0] pair;
    int         k;
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    fuse    <= f;
    step(4);
    @(negedge i_clk);
    check(decoded, '0);
    check({core_run, sda_in}, 2'b01);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    step(1995);
    @(negedge i_clk);
    check(core_run, 1'b0);
    step(10);
    @(negedge i_clk);
    check(core_run, 1'b1);
    check(decoded.wdt_prescale_ratio,
          f.watchdog_prescale_select ? 8'h80 : 8'h20);
    check(decoded.wdt_postscale_ratio,
          16'h0001 << f.watchdog_postscale_select);
    case (f.debug_channel_select)
      2'b11:   pair = 3'b001;
      2'b10:   pair = 3'b010;
      2'b01:   pair = 3'b100;
      default: pair = 3'b000;
    endcase
    check(decoded.debug_pair_onehot, pair);
    check(decoded.debug_select_reserved,
          f.debug_channel_select == 2'b00);
    @(posedge i_clk);
    pwm_high <= 3'b101;
    pwm_low  <= 3'b011;
    step(2);
    @(negedge i_clk);
    check(hi_pin, f.high_side_polarity ? 3'b101 : 3'b010);
    check(lo_pin, f.low_side_polarity ? 3'b011 : 3'b100);
    check({hi_oe, lo_oe}, f.pwm_reset_pin_owner ? 6'h00 : 6'h3F);
    reg_write(ADDR_CONTROL, 32'h0000_0001);
    step(2);
    @(negedge i_clk);
    check({hi_oe, lo_oe}, 6'h3F);
    // outside device holds the unused pair's clock low; must not be seen
    @(posedge i_clk);
    sda_drive <= 1'b1;
    scl_hold  <= f.i2c_pin_alternate_select ? 2'b10 : 2'b01;
    step(4);
    @(negedge i_clk);
    check(pin_oe, f.i2c_pin_alternate_select ? 4'h1 : 4'h4);
    check({pin_out, sda_in, scl_in}, 6'h01);
    @(posedge i_clk);
    sda_drive <= 1'b0;
    scl_drive <= 1'b1;
    step(4);
    @(negedge i_clk);
    check(pin_oe, f.i2c_pin_alternate_select ? 4'h2 : 4'h8);
    check({sda_in, scl_in}, 2'b10);
    @(posedge i_clk);
    scl_drive <= 1'b0;
    scl_hold  <= 2'b00;
    relock    <= 1'b1;
    to_pll    <= 1'b1;
    @(posedge i_clk);
    relock <= 1'b0;
    step(5);
    switch_req <= 1'b1;
    @(posedge i_clk);
    switch_req <= 1'b0;
    k = 0;
    while (switch_done !== 1'b1 && k < 100) begin
      @(negedge i_clk);
      k++;
    end
    if (f.pll_lock_wait_enable) check(k >= 34 && k <= 44, 1'b1);
    else check(k, 2);
    // a switch to another source never waits, whatever the lock setting
    @(posedge i_clk);
    to_pll     <= 1'b0;
    switch_req <= 1'b1;
    @(posedge i_clk);
    switch_req <= 1'b0;
    step(1);
    @(negedge i_clk);
    check(switch_done, 1'b1);
    step(45);
    fuse <= ~f;
    step(5);
    reg_read(ADDR_STATUS, d);
    check(d[13:0], {2'b11, f});
    check(decoded.wdt_postscale_ratio,
          16'h0001 << f.watchdog_postscale_select);
  endtask : run_cfg

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // the whole run is about 11000 cycles; this span leaves ample margin
  initial begin
    #400_000;
    failures++;
    tally_and_finish();
  end

  initial begin
    i_rst_n = 1'b0;
    fuse = '0;
    {power_down, switch_req, to_pll, relock, sda_drive, scl_drive} = '0;
    {pwm_high, pwm_low, scl_hold} = '0;
    bus = '0;
    foreach (cfgs[i]) run_cfg(cfgs[i]);
    reg_read(ADDR_DEVICE_IDENTIFIER, d);
    check(d, {8'h00, ID_VAL});
    reg_write(ADDR_DEVICE_IDENTIFIER, 32'hFFFF_FFFF);
    reg_read(ADDR_DEVICE_IDENTIFIER, d);
    check(d, {8'h00, ID_VAL});
    reg_read(ADDR_SILICON_REVISION, d);
    check(d, {8'h00, REV_VAL});
    reg_write(ADDR_SILICON_REVISION, 32'h0000_0000);
    reg_read(ADDR_SILICON_REVISION, d);
    check(d, {8'h00, REV_VAL});
    reg_read(4'h2, d);
    check(d, 32'h0000_0000);
    @(posedge i_clk);
    power_down <= 1'b1;
    step(10);
    @(negedge i_clk);
    check(core_run, 1'b0);
    @(posedge i_clk);
    power_down <= 1'b0;
    n = 0;
    while (core_run !== 1'b1 && n < 2100) begin
      @(negedge i_clk);
      n++;
    end
    check(n >= 1995 && n <= 2010, 1'b1);
    check(decoded.wdt_postscale_ratio, 16'h4000);
    tally_and_finish();
  end
endmodule : config_fuse_decode_tb
